// file: verilog/cgsc_pkg.sv
// constants and types for the clock gear and standby control block
package cgsc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] CGSC_IDX_OSC0 = 8'hE0;
	localparam logic [7:0] CGSC_IDX_GEAR = 8'hE1;
	localparam logic [7:0] CGSC_IDX_STBY = 8'hE2;
	localparam logic [7:0] CGSC_IDX_MISC = 8'hE3;
	localparam logic [7:0] CGSC_IDX_KEY1 = 8'hE4;
	localparam logic [7:0] CGSC_IDX_KEY2 = 8'hE5;
	localparam logic [7:0] CGSC_IDX_AREA = 8'hE6;
	localparam logic [7:0] CGSC_IDX_DBL = 8'hE8;
	localparam logic [7:0] CGSC_IDX_CORR = 8'hE9;
	localparam int CGSC_ADDR_W = 10;
	// reset values
	localparam logic [7:0] CGSC_RST_OSC0 = 8'hE0;
	localparam logic [7:0] CGSC_RST_GEAR = 8'h04;
	localparam logic [7:0] CGSC_RST_STBY = 8'h2C;
	localparam logic [7:0] CGSC_RST_MISC = 8'h03;
	localparam logic [7:0] CGSC_RST_AREA = 8'h00;
	localparam logic [7:0] CGSC_RST_DBL = 8'h00;
	localparam logic [7:0] CGSC_RST_CORR = 8'h13;
	// oscillator_control_0 fields
	localparam int CGSC_HF_EN = 7;
	localparam int CGSC_LF_EN = 6;
	localparam int CGSC_HF_AFTER = 5;
	localparam int CGSC_LF_AFTER = 4;
	localparam int CGSC_POST_SEL = 3;
	localparam int CGSC_WARMUP_FLAG = 2;
	// clock_select_gear fields
	localparam int CGSC_SYS_SEL = 3;
	// standby_warmup_control fields
	localparam int CGSC_PS_DISABLE = 7;
	localparam int CGSC_DRV_SEL = 1;
	localparam int CGSC_PIN_DRIVE = 0;
	// misc_clock_control fields
	localparam int CGSC_PROTECT = 7;
	localparam int CGSC_DISP_SRC = 6;
	localparam int CGSC_ADDR_HOLD = 5;
	localparam int CGSC_MEL_SRC = 4;
	localparam int CGSC_EXT_HF = 2;
	localparam int CGSC_HF_DRV = 1;
	localparam int CGSC_LF_DRV = 0;
	localparam logic [7:0] CGSC_MISC_RW = 8'h77;
	// area_write_detect and doubler_control masks
	localparam logic [7:0] CGSC_AREA_EN = 8'h70;
	localparam logic [7:0] CGSC_DBL_RW = 8'hD0;
	localparam int CGSC_LOCKUP_FLAG = 5;
	localparam int CGSC_LOCKUP_SEL = 4;
	// protection keys
	localparam logic [7:0] CGSC_KEY_A = 8'h5A;
	localparam logic [7:0] CGSC_KEY_B = 8'hA5;
	// counts in input clock periods
	localparam logic [16:0] CGSC_WARMUP_SHORT = 17'h00100;
	localparam logic [12:0] CGSC_LOCKUP_SHORT = 13'h0400;
	localparam logic [12:0] CGSC_LOCKUP_LONG = 13'h1000;
	typedef enum logic [2:0] {CGSC_RUN, CGSC_STOP, CGSC_IDLE_MODE_ONE, CGSC_IDLE_MODE_TWO, CGSC_WARM} cgsc_mode_e;
endpackage : cgsc_pkg

// file: verilog/cgsc_top.sv
// clock gear, oscillator, warm-up, doubler and standby control with avalon slave
// Function
// - hf oscillator enable: 0 stops, resets 1
// - lf oscillator enable: 0 stops, resets 1
// - oscillator choices after stop release, hf1 lf0
// - clock after stop release: hf or lf
// - write 1 starts warm-up; read busy
// - prescaler clock: fast clock or hf/16
// - system clock: hf (0), lf (1)
// - gear divides hf by 1..16, resets /16
// - warm-up length 2^8, 2^14, 2^16 periods
// - halt mode: stop, idle one, idle two
// - drive setting applies to stop or idle one
// - pin drive held in stop or idle one, as chosen by the drive setting, when set
// - power-save disable bit, resets zero
// - read-only protection flag, resets off
// - address hold enable bit, resets zero
// - external hf clock instead of oscillator
// - oscillator drive strength normal or weak
// - display and melody clock source select
// - doubler action code selects doubler, lock-up, clock
// - lock-up flag high while the lock-up count runs
// - area write detect enables and flags
`timescale 1ns/1ps
module cgsc_top #(
	parameter int WARMUP_MID_CYCLES = 16384,
	parameter int WARMUP_LONG_CYCLES = 65536
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [cgsc_pkg::CGSC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic halt_req,
	input wire logic wake_req,
	input wire logic lf_clock_pin,
	input wire logic area_write_a,
	input wire logic area_write_b,
	input wire logic area_write_c,
	output logic hf_osc_run,
	output logic lf_osc_run,
	output logic system_clock_en,
	output logic prescaler_clock_en,
	output logic system_clock_is_lf,
	output logic core_clock_hold,
	output logic standby_stop,
	output logic standby_idle_one,
	output logic standby_idle_two,
	output logic standby_pin_drive,
	output logic power_save_disable,
	output logic address_hold,
	output logic external_hf_clock,
	output logic hf_osc_drive_strength,
	output logic lf_osc_drive_strength,
	output logic display_clock_src,
	output logic melody_clock_src,
	output logic protect_on,
	output logic clock_doubler_run,
	output logic lockup_logic_run,
	output logic doubled_clock_sel
);
	import cgsc_pkg::*;

	typedef struct packed {
		logic [7:0] osc0;
		logic [7:0] gear;
		logic [7:0] stby;
		logic [7:0] misc;
		logic [7:0] area;
		logic [7:0] dbl;
		logic [7:0] corr;
		logic protect;
		logic [1:0] key_step;
		logic [16:0] wu_cnt;
		logic [12:0] lu_cnt;
		cgsc_mode_e mode;
		logic [3:0] gear_cnt;
		logic [3:0] pre_cnt;
		logic lf_meta;
		logic lf_sync;
		logic lf_prev;
		logic ack;
		logic [31:0] rdata;
		logic hf_run;
		logic lf_run;
		logic sys_en;
		logic pre_en;
		logic sys_lf;
		logic hold;
		logic st_stop;
		logic st_idle_mode_one;
		logic st_idle_mode_two;
		logic pins;
		logic dbl_run;
		logic lu_run;
		logic dbl_sel;
	} cgsc_state_s;

	cgsc_state_s s_q;
	cgsc_state_s s_d;

	function automatic logic [16:0] cgsc_warm_len(input logic [1:0] code);
		unique case (code)
			2'b10: cgsc_warm_len = 17'(WARMUP_MID_CYCLES);
			2'b11: cgsc_warm_len = 17'(WARMUP_LONG_CYCLES);
			default: cgsc_warm_len = CGSC_WARMUP_SHORT;
		endcase
	endfunction : cgsc_warm_len

	function automatic logic [3:0] cgsc_gear_last(input logic [2:0] code);
		unique case (code)
			3'h0: cgsc_gear_last = 4'h0;
			3'h1: cgsc_gear_last = 4'h1;
			3'h2: cgsc_gear_last = 4'h3;
			3'h3: cgsc_gear_last = 4'h7;
			default: cgsc_gear_last = 4'hF;
		endcase
	endfunction : cgsc_gear_last

	logic req;
	logic accept;
	logic hit_word;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic wr_ok;
	logic [7:0] rbyte;
	logic lf_tick;
	logic gear_tick;
	logic hf16_tick;
	logic hf_clk_live;
	logic running;

	always_comb begin
		s_d = s_q;
		req = avs_read | avs_write;
		accept = req & s_q.ack;
		idx = avs_address[CGSC_ADDR_W-1:2];
		hit_word = avs_address[1:0] == 2'h0;
		wbyte = avs_writedata[7:0];
		wr_ok = avs_write & accept & avs_byteenable[0] & hit_word;
		rbyte = 8'h00;
		lf_tick = s_q.lf_sync & ~s_q.lf_prev;
		hf_clk_live = s_q.osc0[CGSC_HF_EN] | s_q.misc[CGSC_EXT_HF];
		gear_tick = hf_clk_live & (s_q.gear_cnt >= cgsc_gear_last(s_q.gear[2:0]));
		hf16_tick = hf_clk_live & (s_q.pre_cnt == 4'hF);
		running = s_q.mode == CGSC_RUN;

		// lf clock pin synchroniser
		s_d.lf_meta = lf_clock_pin;
		s_d.lf_sync = s_q.lf_meta;
		s_d.lf_prev = s_q.lf_sync;

		// gear divider and hf/16 divider
		s_d.gear_cnt = gear_tick ? 4'h0 : s_q.gear_cnt + 4'h1;
		s_d.pre_cnt = s_q.pre_cnt + 4'h1;

		// one wait state, then the answer
		s_d.ack = req & ~s_q.ack;
		if (hit_word) begin
			unique case (idx)
				CGSC_IDX_OSC0: rbyte = {s_q.osc0[7:3], s_q.wu_cnt != 17'h0, s_q.osc0[1:0]};
				CGSC_IDX_GEAR: rbyte = s_q.gear;
				CGSC_IDX_STBY: rbyte = s_q.stby;
				CGSC_IDX_MISC: rbyte = {s_q.protect, s_q.misc[6:0]};
				CGSC_IDX_AREA: rbyte = s_q.area;
				CGSC_IDX_DBL: rbyte = {s_q.dbl[7:6], s_q.lu_cnt != 13'h0, s_q.dbl[4:0]};
				CGSC_IDX_CORR: rbyte = s_q.corr;
				default: rbyte = 8'h00;
			endcase
		end
		if (avs_read & ~s_q.ack) begin
			s_d.rdata = {24'h000000, rbyte};
		end

		// warm-up and lock-up counters
		if (s_q.wu_cnt != 17'h0) begin
			s_d.wu_cnt = s_q.wu_cnt - 17'h1;
		end
		if (s_q.lu_cnt != 13'h0) begin
			s_d.lu_cnt = s_q.lu_cnt - 13'h1;
		end
		if (s_q.dbl[7:6] != 2'b01) begin
			s_d.lu_cnt = 13'h0;
		end

		// area write detection, set wins over clear
		if (wr_ok && idx == CGSC_IDX_AREA) begin
			s_d.area = (wbyte & CGSC_AREA_EN) | (s_q.area & wbyte & 8'h07);
		end
		if (area_write_a & s_q.area[6]) begin
			s_d.area[2] = 1'b1;
		end
		if (area_write_b & s_q.area[5]) begin
			s_d.area[1] = 1'b1;
		end
		if (area_write_c & s_q.area[4]) begin
			s_d.area[0] = 1'b1;
		end

		// register writes
		if (wr_ok) begin
			unique case (idx)
				CGSC_IDX_OSC0: begin
					s_d.osc0 = {wbyte[7:3], 1'b0, wbyte[1:0]};
					if (wbyte[CGSC_WARMUP_FLAG]) begin
						s_d.wu_cnt = cgsc_warm_len(s_q.stby[5:4]);
					end
				end
				CGSC_IDX_GEAR: s_d.gear = wbyte & 8'h0F;
				CGSC_IDX_STBY: s_d.stby = wbyte & 8'hBF;
				CGSC_IDX_MISC: s_d.misc = wbyte & CGSC_MISC_RW;
				CGSC_IDX_DBL: begin
					s_d.dbl = wbyte & CGSC_DBL_RW;
					if (wbyte[7:6] == 2'b01 && s_q.dbl[7:6] != 2'b01) begin
						s_d.lu_cnt = wbyte[CGSC_LOCKUP_SEL] ? CGSC_LOCKUP_SHORT : CGSC_LOCKUP_LONG;
					end
				end
				CGSC_IDX_CORR: s_d.corr = wbyte;
				default: begin
				end
			endcase
			// key sequence: 5A, A5 then A5, 5A on consecutive writes
			s_d.key_step = 2'h0;
			unique case (s_q.key_step)
				2'h0: if (idx == CGSC_IDX_KEY1 && wbyte == CGSC_KEY_A) s_d.key_step = 2'h1;
				2'h1: if (idx == CGSC_IDX_KEY2 && wbyte == CGSC_KEY_B) s_d.key_step = 2'h2;
				2'h2: if (idx == CGSC_IDX_KEY1 && wbyte == CGSC_KEY_B) s_d.key_step = 2'h3;
				2'h3: if (idx == CGSC_IDX_KEY2 && wbyte == CGSC_KEY_A) s_d.protect = ~s_q.protect;
			endcase
			if (s_d.key_step == 2'h0 && idx == CGSC_IDX_KEY1 && wbyte == CGSC_KEY_A) begin
				s_d.key_step = 2'h1;
			end
		end

		// standby sequencing
		unique case (s_q.mode)
			CGSC_RUN: begin
				if (halt_req) begin
					unique case (s_q.stby[3:2])
						2'b01: s_d.mode = CGSC_STOP;
						2'b10: s_d.mode = CGSC_IDLE_MODE_ONE;
						2'b11: s_d.mode = CGSC_IDLE_MODE_TWO;
						default: s_d.mode = CGSC_RUN;
					endcase
				end
			end
			CGSC_STOP: begin
				if (wake_req) begin
					s_d.osc0[CGSC_HF_EN] = s_q.osc0[CGSC_HF_AFTER];
					s_d.osc0[CGSC_LF_EN] = s_q.osc0[CGSC_LF_AFTER];
					s_d.gear[CGSC_SYS_SEL] = s_q.osc0[CGSC_POST_SEL];
					s_d.wu_cnt = cgsc_warm_len(s_q.stby[5:4]);
					s_d.mode = CGSC_WARM;
				end
			end
			CGSC_IDLE_MODE_ONE, CGSC_IDLE_MODE_TWO: begin
				if (wake_req) begin
					s_d.mode = CGSC_RUN;
				end
			end
			CGSC_WARM: begin
				if (s_q.wu_cnt == 17'h0) begin
					s_d.mode = CGSC_RUN;
				end
			end
			default: s_d.mode = CGSC_RUN;
		endcase

		// registered outputs
		s_d.hf_run = s_q.osc0[CGSC_HF_EN] & (s_q.mode != CGSC_STOP);
		s_d.lf_run = s_q.osc0[CGSC_LF_EN] & (s_q.mode != CGSC_STOP);
		s_d.sys_lf = s_q.gear[CGSC_SYS_SEL];
		s_d.sys_en = running & (s_q.gear[CGSC_SYS_SEL] ? (lf_tick & s_q.osc0[CGSC_LF_EN]) : gear_tick);
		unique case (s_q.osc0[1:0])
			2'b00: s_d.pre_en = running & gear_tick;
			2'b10: s_d.pre_en = running & hf16_tick;
			default: s_d.pre_en = 1'b0;
		endcase
		s_d.hold = ~running;
		s_d.st_stop = s_q.mode == CGSC_STOP;
		s_d.st_idle_mode_one = s_q.mode == CGSC_IDLE_MODE_ONE;
		s_d.st_idle_mode_two = s_q.mode == CGSC_IDLE_MODE_TWO;
		s_d.pins = s_q.stby[CGSC_PIN_DRIVE] & (s_q.stby[CGSC_DRV_SEL] ? s_q.mode == CGSC_STOP
			: s_q.mode == CGSC_IDLE_MODE_ONE);
		s_d.dbl_run = s_q.dbl[7:6] != 2'b00;
		s_d.lu_run = s_q.dbl[7:6] == 2'b01;
		s_d.dbl_sel = s_q.dbl[7:6] == 2'b10;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.osc0 <= CGSC_RST_OSC0;
			s_q.gear <= CGSC_RST_GEAR;
			s_q.stby <= CGSC_RST_STBY;
			s_q.misc <= CGSC_RST_MISC;
			s_q.area <= CGSC_RST_AREA;
			s_q.dbl <= CGSC_RST_DBL;
			s_q.corr <= CGSC_RST_CORR;
			s_q.mode <= CGSC_RUN;
			s_q.hf_run <= 1'b1;
			s_q.lf_run <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = ~s_q.ack;
	assign hf_osc_run = s_q.hf_run;
	assign lf_osc_run = s_q.lf_run;
	assign system_clock_en = s_q.sys_en;
	assign prescaler_clock_en = s_q.pre_en;
	assign system_clock_is_lf = s_q.sys_lf;
	assign core_clock_hold = s_q.hold;
	assign standby_stop = s_q.st_stop;
	assign standby_idle_one = s_q.st_idle_mode_one;
	assign standby_idle_two = s_q.st_idle_mode_two;
	assign standby_pin_drive = s_q.pins;
	assign power_save_disable = s_q.stby[CGSC_PS_DISABLE];
	assign address_hold = s_q.misc[CGSC_ADDR_HOLD];
	assign external_hf_clock = s_q.misc[CGSC_EXT_HF];
	assign hf_osc_drive_strength = s_q.misc[CGSC_HF_DRV];
	assign lf_osc_drive_strength = s_q.misc[CGSC_LF_DRV];
	assign display_clock_src = s_q.misc[CGSC_DISP_SRC];
	assign melody_clock_src = s_q.misc[CGSC_MEL_SRC];
	assign protect_on = s_q.protect;
	assign clock_doubler_run = s_q.dbl_run;
	assign lockup_logic_run = s_q.lu_run;
	assign doubled_clock_sel = s_q.dbl_sel;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_hf_osc_stop: assert property (s_q.osc0[CGSC_HF_EN] == 1'b0 |=> !hf_osc_run)
		else $error("hf oscillator runs while disabled");
	a_lf_osc_stop: assert property (s_q.osc0[CGSC_LF_EN] == 1'b0 |=> !lf_osc_run)
		else $error("lf oscillator runs while disabled");
	a_stop_release: assert property (s_q.mode == CGSC_STOP && wake_req |=>
		s_q.osc0[CGSC_HF_EN] == $past(s_q.osc0[CGSC_HF_AFTER]) && s_q.mode == CGSC_WARM)
		else $error("stop release did not apply after-stop oscillator choice");
	a_warmup_short: assert property (wr_ok && idx == CGSC_IDX_OSC0 && wbyte[2] && s_q.stby[5:4] == 2'b01
		|=> s_q.wu_cnt == 17'h00100 ##256 s_q.wu_cnt == 17'h0)
		else $error("short warm-up count wrong");
	a_warmup_read: assert property (avs_read && !s_q.ack && hit_word && idx == CGSC_IDX_OSC0
		|=> avs_readdata[2] == ($past(s_q.wu_cnt) != 17'h0))
		else $error("warm-up flag readback wrong");
	a_gear_full: assert property (s_q.gear[3:0] == 4'h0 && running && hf_clk_live |=> system_clock_en)
		else $error("undivided gear missed a tick");
	a_halt_stop: assert property (running && halt_req && s_q.stby[3:2] == 2'b01 |-> ##2 standby_stop)
		else $error("halt did not enter stop");
	a_pin_drive: assert property (standby_pin_drive |-> $past(s_q.stby[CGSC_PIN_DRIVE]))
		else $error("pins driven without pin drive bit");
	a_doubler_off: assert property (s_q.dbl[7:6] == 2'b00 |=> !clock_doubler_run && !lockup_logic_run)
		else $error("doubler runs in stop code");
	a_area_flag: assert property (area_write_a && s_q.area[6] |=> s_q.area[2])
		else $error("area write flag not set");
	a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

	c_stop_cycle: cover property (s_q.mode == CGSC_STOP ##[1:50] s_q.mode == CGSC_WARM);
	c_protect_toggle: cover property ($rose(s_q.protect));
	c_lockup_end: cover property ($fell(lockup_logic_run));
	c_area_clear: cover property ($fell(s_q.area[2]));
endmodule : cgsc_top

// file: bench/cgsc_top_test.sv
// self-checking testbench for the clock gear and standby control block
`timescale 1ns/1ps
module cgsc_top_test;
	import cgsc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [CGSC_ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic halt_req = 1'b0;
	logic wake_req = 1'b0;
	logic lf_pin = 1'b0;
	logic [3:0] lf_div = 4'h0;
	logic [2:0] area_wr = 3'h0;
	logic hf_run, lf_run, sys_en, pre_en, sys_lf, hold, s_stop, s_idle_mode_one, s_idle_mode_two, pin_drv;
	logic ps_dis, a_hold, ext_hf, hf_drv, lf_drv, disp_src, mel_src, prot, dbl_run, lup_run, dbl_sel;
	int num_errors = 0;
	int cmp_count = 0;
	cgsc_top #(.WARMUP_MID_CYCLES(64), .WARMUP_LONG_CYCLES(128)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_req(halt_req),
		.wake_req(wake_req), .lf_clock_pin(lf_pin), .area_write_a(area_wr[2]), .area_write_b(area_wr[1]),
		.area_write_c(area_wr[0]), .hf_osc_run(hf_run), .lf_osc_run(lf_run), .system_clock_en(sys_en),
		.prescaler_clock_en(pre_en), .system_clock_is_lf(sys_lf), .core_clock_hold(hold),
		.standby_stop(s_stop), .standby_idle_one(s_idle_mode_one), .standby_idle_two(s_idle_mode_two),
		.standby_pin_drive(pin_drv), .power_save_disable(ps_dis), .address_hold(a_hold),
		.external_hf_clock(ext_hf), .hf_osc_drive_strength(hf_drv), .lf_osc_drive_strength(lf_drv),
		.display_clock_src(disp_src), .melody_clock_src(mel_src), .protect_on(prot),
		.clock_doubler_run(dbl_run), .lockup_logic_run(lup_run), .doubled_clock_sel(dbl_sel)
	);
	always #20 sys_clk = ~sys_clk;
	// low-frequency pin: one rising edge every 16 system cycles
	always @(posedge sys_clk) begin
		lf_div <= lf_div + 4'h1;
		lf_pin <= lf_div[3];
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d, output logic [7:0] q);
		avs_address <= {ix, 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, ix, d, q);
	endtask : wr
	task automatic rc(input logic [7:0] ix, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, ix, 8'h00, q);
		chk(q, e);
	endtask : rc
	task automatic cnt(input logic p, output logic [7:0] n);
		n = 8'h00;
		repeat (64) begin
			@(posedge sys_clk);
			n = n + {7'h00, p ? pre_en : sys_en};
		end
	endtask : cnt
	task automatic t_reset;
		logic [7:0] ix [10];
		logic [7:0] ex [10];
		ix = '{CGSC_IDX_OSC0, CGSC_IDX_GEAR, CGSC_IDX_STBY, CGSC_IDX_MISC, CGSC_IDX_KEY1, CGSC_IDX_KEY2,
			CGSC_IDX_AREA, CGSC_IDX_DBL, CGSC_IDX_CORR, 8'hE7};
		ex = '{8'hE0, 8'h04, 8'h2C, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00};
		chk({hf_run, lf_run, hf_drv, lf_drv, prot, hold, sys_lf, dbl_run}, 8'hF0);
		for (int i = 0; i < 10; i++) rc(ix[i], ex[i]);
		$display("test reset done");
	endtask : t_reset
	task automatic t_misc;
		wr(CGSC_IDX_MISC, 8'hFF);
		rc(CGSC_IDX_MISC, 8'h77);
		chk({disp_src, a_hold, mel_src, ext_hf, hf_drv, lf_drv, prot, ps_dis}, 8'hFC);
		wr(CGSC_IDX_MISC, 8'h00);
		wr(CGSC_IDX_STBY, 8'hAC);
		tick(2);
		chk({disp_src, a_hold, mel_src, ext_hf, hf_drv, lf_drv, prot, ps_dis}, 8'h01);
		wr(CGSC_IDX_MISC, 8'h03);
		wr(CGSC_IDX_STBY, 8'h2C);
		$display("test misc done");
	endtask : t_misc
	task automatic t_gear;
		logic [7:0] n;
		logic [7:0] pe [4];
		pe = '{8'h40, 8'h00, 8'h04, 8'h00};
		for (int k = 0; k < 5; k++) begin
			wr(CGSC_IDX_GEAR, 8'(k));
			tick(4);
			cnt(1'b0, n);
			chk(n, 8'(64 >> k));
		end
		wr(CGSC_IDX_GEAR, 8'h08);
		tick(4);
		cnt(1'b0, n);
		chk({n[6:0], sys_lf}, 8'h09);
		wr(CGSC_IDX_GEAR, 8'h00);
		for (int j = 0; j < 4; j++) begin
			wr(CGSC_IDX_OSC0, 8'hE0 | 8'(j));
			tick(4);
			cnt(1'b1, n);
			chk(n, pe[j]);
		end
		wr(CGSC_IDX_OSC0, 8'hE0);
		wr(CGSC_IDX_GEAR, 8'h04);
		$display("test gear done");
	endtask : t_gear
	task automatic keys(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
		wr(CGSC_IDX_KEY1, a);
		wr(CGSC_IDX_KEY2, b);
		wr(CGSC_IDX_KEY1, c);
		wr(CGSC_IDX_KEY2, d);
		tick(2);
	endtask : keys
	task automatic t_prot;
		keys(8'h5A, 8'hA5, 8'hA5, 8'h5A);
		rc(CGSC_IDX_MISC, 8'h83);
		keys(8'h5A, 8'h00, 8'hA5, 8'h5A);
		chk({7'h00, prot}, 8'h01);
		keys(8'h5A, 8'hA5, 8'hA5, 8'h5A);
		chk({7'h00, prot}, 8'h00);
		$display("test protect done");
	endtask : t_prot
	task automatic t_warm;
		logic [7:0] sb [3];
		int ln [3];
		sb = '{8'h17, 8'h27, 8'h37};
		ln = '{256, 64, 128};
		for (int i = 0; i < 3; i++) begin
			wr(CGSC_IDX_STBY, sb[i]);
			wr(CGSC_IDX_OSC0, 8'hE4);
			tick(ln[i] - 30);
			rc(CGSC_IDX_OSC0, 8'hE4);
			wr(CGSC_IDX_OSC0, 8'hE0);
			rc(CGSC_IDX_OSC0, 8'hE4);
			tick(40);
			rc(CGSC_IDX_OSC0, 8'hE0);
		end
		$display("test warmup done");
	endtask : t_warm
	task automatic hw(input logic [7:0] sb, input logic [7:0] e);
		wr(CGSC_IDX_STBY, sb);
		halt_req <= 1'b1;
		tick(1);
		halt_req <= 1'b0;
		tick(3);
		chk({s_stop, s_idle_mode_one, s_idle_mode_two, hold, pin_drv, hf_run, lf_run, sys_en}, e);
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(3);
	endtask : hw
	task automatic t_halt;
		wr(CGSC_IDX_OSC0, 8'hF8);
		hw(8'h17, 8'h98);
		chk({s_stop, hold, hf_run, lf_run, sys_lf, 3'h0}, 8'h78);
		tick(300);
		chk({s_stop, hold, hf_run, lf_run, sys_lf, 3'h0}, 8'h38);
		wr(CGSC_IDX_GEAR, 8'h04);
		wr(CGSC_IDX_OSC0, 8'hE0);
		hw(8'h29, 8'h5E);
		chk({s_idle_mode_one, hold, 6'h00}, 8'h00);
		hw(8'h2C, 8'h36);
		chk({s_idle_mode_two, hold, 6'h00}, 8'h00);
		wr(CGSC_IDX_GEAR, 8'h00);
		hw(8'h20, 8'h07);
		wr(CGSC_IDX_GEAR, 8'h04);
		$display("test halt done");
	endtask : t_halt
	task automatic t_area;
		wr(CGSC_IDX_AREA, 8'h70);
		area_wr <= 3'h7;
		tick(1);
		area_wr <= 3'h0;
		tick(2);
		rc(CGSC_IDX_AREA, 8'h77);
		wr(CGSC_IDX_AREA, 8'h00);
		rc(CGSC_IDX_AREA, 8'h00);
		area_wr <= 3'h5;
		tick(1);
		area_wr <= 3'h0;
		tick(2);
		rc(CGSC_IDX_AREA, 8'h00);
		$display("test area done");
	endtask : t_area
	task automatic t_dbl;
		logic [7:0] ac [4];
		logic [7:0] ex [4];
		ac = '{8'h40, 8'h80, 8'hC0, 8'h00};
		ex = '{8'hC0, 8'hA0, 8'h80, 8'h00};
		wr(CGSC_IDX_CORR, 8'h0B);
		rc(CGSC_IDX_CORR, 8'h0B);
		wr(CGSC_IDX_DBL, 8'h40);
		rc(CGSC_IDX_DBL, 8'h60);
		tick(4100);
		rc(CGSC_IDX_DBL, 8'h40);
		wr(CGSC_IDX_DBL, 8'h00);
		wr(CGSC_IDX_DBL, 8'h50);
		tick(980);
		rc(CGSC_IDX_DBL, 8'h70);
		tick(60);
		rc(CGSC_IDX_DBL, 8'h50);
		for (int i = 0; i < 4; i++) begin
			wr(CGSC_IDX_DBL, ac[i]);
			tick(2);
			chk({dbl_run, lup_run, dbl_sel, 5'h00}, ex[i]);
		end
		$display("test doubler done");
	endtask : t_dbl
	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		tick(1);
		t_reset();
		t_misc();
		t_gear();
		t_prot();
		t_warm();
		t_halt();
		t_area();
		t_dbl();
		conclude();
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		conclude();
	end
endmodule : cgsc_top_test
